// ==== design/hbs_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------
// Shared constants for the holding brake sequencer
// ----------------------------------------------------------------------
package hbs_pkg;
    // Width of the delay settings and of the speed words
    localparam int HBS_DLY_W = 16;
    localparam int HBS_SPD_W = 16;
    // Milliseconds per delay unit, clock rate in MHz
    localparam int HBS_TICK_MS = 1;
    localparam int HBS_CLK_MHZ = 125;
    // Clock cycles per delay unit, derived from the two figures above
    localparam int HBS_TICK_CYC = HBS_TICK_MS * HBS_CLK_MHZ * 1000;
    // Reset value of the tick prescaler
    localparam logic [16:0] HBS_PRE_ZERO = 17'h00000;
    localparam logic [16:0] HBS_PRE_ONE = 17'h00001;
    localparam logic [15:0] HBS_CNT_ZERO = 16'h0000;
    localparam logic [15:0] HBS_CNT_ONE = 16'h0001;

    // Sequencer states
    typedef enum logic [1:0] {
        HBS_ENGAGED  = 2'b00,
        HBS_ON_WAIT  = 2'b01,
        HBS_RELEASED = 2'b10,
        HBS_OFF_WAIT = 2'b11
    } hbs_state_e;
endpackage : hbs_pkg
`default_nettype wire

// ==== design/hbs_sequencer.sv ====
`default_nettype none
// Behaviour
// [R1] A low output means the brake holds the motor, high means released.
// [R2] Separate on and off delay settings time release and engage.
// [R3] After servo off the output drops when the off delay ends, any speed.
// [R4] After servo off the output drops early once speed is below threshold.
// [R5] Without a stop, the brake engages only after servo off, never while driven.
// [R6] An emergency stop drops the output at once and holds it low.
// [R7] After servo on the output rises once the on delay has run out.
module hbs_sequencer
    import hbs_pkg::*;
#(
    parameter int TICK_CYC = HBS_TICK_CYC
)(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SERVO_ON_IN,
    input wire logic ESTOP_IN,
    input wire logic [HBS_DLY_W-1:0] BRAKE_ON_DELAY_PARAM,
    input wire logic [HBS_DLY_W-1:0] BRAKE_OFF_DELAY_PARAM,
    input wire logic [HBS_SPD_W-1:0] ZERO_SPEED_THRESHOLD_PARAM,
    input wire logic [HBS_SPD_W-1:0] MOTOR_SPEED,
    output logic BRAKE_RELEASE_OUT
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic son_meta, son_sync, stop_meta, stop_sync;

    // Servo-on and stop come from pins, so each passes two flops
    always_ff @(posedge MCLK)
    begin
        son_meta <= RST_N ? SERVO_ON_IN : 1'b0;
        son_sync <= RST_N ? son_meta : 1'b0;
        stop_meta <= RST_N ? ESTOP_IN : 1'b1;
        stop_sync <= RST_N ? stop_meta : 1'b1;
    end

    // ------------------------------------------------------------------
    // Delay timebase and counter
    // ------------------------------------------------------------------
    hbs_state_e state, next_state;
    logic [16:0] pre;
    logic [HBS_DLY_W-1:0] cnt;
    wire tick = (pre == 17'(TICK_CYC - 1));
    wire entering_wait = (next_state != state) &&
        (next_state == HBS_ON_WAIT || next_state == HBS_OFF_WAIT);
    wire [HBS_DLY_W-1:0] load_val =
        (next_state == HBS_ON_WAIT) ? BRAKE_ON_DELAY_PARAM
                                    : BRAKE_OFF_DELAY_PARAM; // [R2]
    wire expired = (cnt == HBS_CNT_ZERO);
    wire slow = (MOTOR_SPEED < ZERO_SPEED_THRESHOLD_PARAM);

    // Prescaler restarts on each new wait so a delay is never short
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || entering_wait || tick)
            pre <= HBS_PRE_ZERO;
        else
            pre <= pre + HBS_PRE_ONE;
    end

    // Counts delay units down; a zero setting means no wait
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            cnt <= HBS_CNT_ZERO;
        else if (entering_wait)
            cnt <= load_val; // [R2]
        else if (tick && !expired)
            cnt <= cnt - HBS_CNT_ONE;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Stop outranks everything; servo off cancels a pending release
    always_comb
    begin
        next_state = state;
        unique case (state)
            HBS_ENGAGED:
                if (son_sync && !stop_sync)
                    next_state = HBS_ON_WAIT;
            HBS_ON_WAIT:
                if (stop_sync || !son_sync)
                    next_state = HBS_ENGAGED;
                else if (expired)
                    next_state = HBS_RELEASED; // [R7]
            HBS_RELEASED:
                if (stop_sync)
                    next_state = HBS_ENGAGED; // [R6]
                else if (!son_sync)
                    next_state = HBS_OFF_WAIT; // [R5]
            // Servo back on wins over expiry, so the brake never drops
            // onto a motor that is being driven again
            HBS_OFF_WAIT:
                if (stop_sync)
                    next_state = HBS_ENGAGED; // [R6]
                else if (son_sync)
                    next_state = HBS_RELEASED; // [R5]
                else if (expired || slow)
                    next_state = HBS_ENGAGED; // [R3] [R4]
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        state <= RST_N ? next_state : HBS_ENGAGED;
    end

    // Output registered; only the released and off-wait states free it
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            BRAKE_RELEASE_OUT <= 1'b0;
        else
            BRAKE_RELEASE_OUT <= (next_state == HBS_RELEASED) ||
                                 (next_state == HBS_OFF_WAIT); // [R1]
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_stop_engages;
        @(posedge MCLK) disable iff (!RST_N)
        stop_sync |=> !BRAKE_RELEASE_OUT;
    endproperty
    a_stop_engages: assert property (p_stop_engages) // [R6]
        else $error("stop did not engage brake");

    property p_release_needs_son;
        @(posedge MCLK) disable iff (!RST_N)
        $rose(BRAKE_RELEASE_OUT) |-> $past(son_sync);
    endproperty
    a_release_needs_son: assert property (p_release_needs_son) // [R7]
        else $error("release without servo on");

    property p_engage_after_off;
        @(posedge MCLK) disable iff (!RST_N)
        $fell(BRAKE_RELEASE_OUT) |-> $past(!son_sync || stop_sync);
    endproperty
    a_engage_after_off: assert property (p_engage_after_off) // [R5]
        else $error("brake engaged while servo on");

    property p_slow_drops;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_OFF_WAIT && slow && !son_sync) |=> !BRAKE_RELEASE_OUT;
    endproperty
    a_slow_drops: assert property (p_slow_drops) // [R4]
        else $error("slow motor did not engage brake");

    property p_expiry_drops;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_OFF_WAIT && expired && !son_sync)
            |=> !BRAKE_RELEASE_OUT;
    endproperty
    a_expiry_drops: assert property (p_expiry_drops) // [R3]
        else $error("off delay expiry did not engage brake");

    property p_on_expiry;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_ON_WAIT && expired && son_sync && !stop_sync)
            |=> BRAKE_RELEASE_OUT;
    endproperty
    a_on_expiry: assert property (p_on_expiry) // [R2]
        else $error("on delay expiry did not release brake");

    property p_out_state;
        @(posedge MCLK) disable iff (!RST_N)
        BRAKE_RELEASE_OUT == (state == HBS_RELEASED ||
                              state == HBS_OFF_WAIT);
    endproperty
    a_out_state: assert property (p_out_state) // [R1]
        else $error("output disagrees with state");

    // ------------------------------------------------------------------
    // Checks on waits, cancels and the stop lock
    // ------------------------------------------------------------------
    property p_on_holds;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_ON_WAIT && !expired) |=> !BRAKE_RELEASE_OUT;
    endproperty
    a_on_holds: assert property (p_on_holds) // [R7]
        else $error("brake released before on delay ran out");

    property p_on_wait_cancel;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_ON_WAIT && (!son_sync || stop_sync))
            |=> (state == HBS_ENGAGED && !BRAKE_RELEASE_OUT);
    endproperty
    a_on_wait_cancel: assert property (p_on_wait_cancel) // [R7]
        else $error("pending release not cancelled");

    property p_resume;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_OFF_WAIT && son_sync && !stop_sync)
            |=> (state == HBS_RELEASED && BRAKE_RELEASE_OUT);
    endproperty
    a_resume: assert property (p_resume) // [R5]
        else $error("servo on during off wait did not resume");

    property p_fast_holds;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_OFF_WAIT && !expired && !slow && !son_sync &&
         !stop_sync) |=> BRAKE_RELEASE_OUT;
    endproperty
    a_fast_holds: assert property (p_fast_holds) // [R3]
        else $error("brake engaged before off delay ran out");

    property p_stop_stays;
        @(posedge MCLK) disable iff (!RST_N)
        (state == HBS_ENGAGED && stop_sync) |=> state == HBS_ENGAGED;
    endproperty
    a_stop_stays: assert property (p_stop_stays) // [R6]
        else $error("sequencer left engaged during stop");

    // Delay word is captured as the wait starts, later edits wait a turn
    property p_load_delay;
        @(posedge MCLK) disable iff (!RST_N)
        entering_wait |=> cnt == $past(load_val);
    endproperty
    a_load_delay: assert property (p_load_delay) // [R2]
        else $error("delay setting not loaded");

endmodule // hbs_sequencer
`default_nettype wire

// ==== verification/hbs_brake_relay.sv ====
`default_nettype none
// ----------------------------------------------------------------------
// Relay that switches the holding brake coil
// ----------------------------------------------------------------------
module hbs_brake_relay (
    input wire logic clk,
    input wire logic coil,
    output logic brake_free
);
    // Contact follows the coil one cycle late, like a slow pickup
    always_ff @(posedge clk)
    begin
        brake_free <= coil; // Energised coil releases the brake
    end
endmodule // hbs_brake_relay
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
module testbench import hbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    logic mclk, rst_n, servo_on_in, estop, brk, free;
    logic [15:0] on_dly, off_dly, thr, spd;
    int error_cnt, n_tests;
    hbs_sequencer #(.TICK_CYC(TC)) i_hbs_sequencer (.MCLK(mclk),
        .RST_N(rst_n), .SERVO_ON_IN(servo_on_in), .ESTOP_IN(estop),
        .BRAKE_ON_DELAY_PARAM(on_dly), .BRAKE_OFF_DELAY_PARAM(off_dly),
        .ZERO_SPEED_THRESHOLD_PARAM(thr), .MOTOR_SPEED(spd),
        .BRAKE_RELEASE_OUT(brk));
    hbs_brake_relay i_hbs_brake_relay (.clk(mclk), .coil(brk),
        .brake_free(free));
    // ------------------------------------------------------------------
    // Clock and shared helpers
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // On delay of three units must hold the brake for at least 12 cycles
    task automatic t_release;
        servo_on_in = 1'b1;
        wait_n(12);
        check("early release", 1'b0, brk);
        wait_n(12);
        check("released", 1'b1, brk);
        check("relay free", 1'b1, free);
        $display("test release done");
    endtask
    // Slow motor while driven must not engage; servo off then cuts early
    task automatic t_speed_low;
        spd = 16'h0000;
        wait_n(8);
        check("held while driven", 1'b1, brk);
        off_dly = 16'h0064;
        servo_on_in = 1'b0;
        wait_n(8);
        check("early engage", 1'b0, brk);
        $display("test speed low done");
    endtask
    // Fast motor: engage waits out the whole off delay of 20 cycles
    task automatic t_off_delay;
        spd = 16'h0100;
        servo_on_in = 1'b1;
        wait_n(24);
        off_dly = 16'h0005;
        servo_on_in = 1'b0;
        wait_n(20);
        check("off delay running", 1'b1, brk);
        wait_n(12);
        check("engaged after delay", 1'b0, brk);
        $display("test off delay done");
    endtask
    // Stop drops the output fast and keeps servo on from releasing it
    task automatic t_estop;
        servo_on_in = 1'b1;
        wait_n(24);
        check("released before stop", 1'b1, brk);
        estop = 1'b1;
        wait_n(6);
        check("stop engage", 1'b0, brk);
        wait_n(30);
        check("stop holds", 1'b0, brk);
        estop = 1'b0;
        servo_on_in = 1'b0;
        wait_n(8);
        $display("test estop done");
    endtask
    // Servo off cancels a pending release; stop refuses servo on
    task automatic t_cancel;
        servo_on_in = 1'b1;
        wait_n(6);
        servo_on_in = 1'b0;
        wait_n(24);
        check("on wait cancelled", 1'b0, brk);
        estop = 1'b1;
        wait_n(4);
        servo_on_in = 1'b1;
        wait_n(30);
        check("stop refuses on", 1'b0, brk);
        estop = 1'b0;
        wait_n(24);
        check("on after stop", 1'b1, brk);
        servo_on_in = 1'b0;
        wait_n(32);
        check("off after delay", 1'b0, brk);
        $display("test cancel done");
    endtask
    // Servo back on during the off wait keeps the brake released
    task automatic t_resume;
        servo_on_in = 1'b1;
        wait_n(24);
        check("released again", 1'b1, brk);
        servo_on_in = 1'b0;
        wait_n(6);
        servo_on_in = 1'b1;
        wait_n(24);
        check("resumed release", 1'b1, brk);
        servo_on_in = 1'b0;
        spd = 16'h0000;
        wait_n(8);
        check("slow engage", 1'b0, brk);
        spd = 16'h0100;
        $display("test resume done");
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        n_tests = 0;
        rst_n = 1'b0;
        servo_on_in = 1'b0;
        estop = 1'b0;
        on_dly = 16'h0003;
        off_dly = 16'h0000;
        thr = 16'h0010;
        spd = 16'h0100;
        wait_n(2); // Synchronisers reload constants while reset is low
        check("reset level", 1'b0, brk);
        rst_n = 1'b1;
        t_release();
        t_speed_low();
        t_off_delay();
        t_estop();
        t_cancel();
        t_resume();
        give_verdict();
    end
    initial
    begin
        #20us;
        error_cnt++;
        $display("Watchdog expired");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
